// file: src/amp_stage.sv
// Mask handling, exit port selection and policer hierarchy of the analyzer
`timescale 1ns/1ps
`default_nettype none
module amp_stage import amp_pkg::*; #(
  parameter int SLB_TICK  = SLB_TICK_CYC,   // Single bucket leak period
  parameter int FINE_TICK = FINE_TICK_CYC   // Fine scale leak period
) (
  input  wire logic        aclk,       // Clock, 100 MHz
  input  wire logic        aresetn,    // Synchronous reset, low
  input  wire logic [11:0] awaddr,     // Write address
  input  wire logic        awvalid,    // Write address valid
  output logic             awready,    // Write address ready
  input  wire logic [31:0] wdata,      // Write data
  input  wire logic [3:0]  wstrb,      // Write byte enables
  input  wire logic        wvalid,     // Write data valid
  output logic             wready,     // Write data ready
  output logic [1:0]       bresp,      // Write response
  output logic             bvalid,     // Write response valid
  input  wire logic        bready,     // Write response ready
  input  wire logic [11:0] araddr,     // Read address
  input  wire logic        arvalid,    // Read address valid
  output logic             arready,    // Read address ready
  output logic [31:0]      rdata,      // Read data
  output logic [1:0]       rresp,      // Read response
  output logic             rvalid,     // Read data valid
  input  wire logic        rready,     // Read data ready
  input  wire logic        req_valid,  // Frame decision in
  input  wire amp_req_t    req,        // Frame decision fields
  output logic             res_valid,  // Final decision out
  output var amp_res_t     res,        // Final decision fields
  output logic [14:0]      fc_pause    // Port policer flow control
);
  typedef struct packed {
    logic                          aw_held;
    logic [11:0]                   aw_addr;
    logic                          w_held;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic [2:0]                    ctrl;
    logic [NCFG-1:0][31:0]         cfg;
    logic [NLVL-1:0][15:0]         lvl;
    logic [NPORT-1:0]              fc;
    logic [15:0]                   slb_cnt;
    logic [15:0]                   fine_cnt;
    logic [6:0]                    coarse_cnt;
    logic [31:0]                   green_cnt;
    logic [31:0]                   yellow_cnt;
    logic [31:0]                   drop_cnt;
    logic                          res_valid;
    amp_res_t                      res;
  } amp_st_t;

  localparam amp_st_t ST_RST = '0;

  amp_st_t               s_r;
  amp_st_t               s_nxt;
  logic [NSLOT-1:0][7:0]  sidx;
  logic [NSLOT-1:0][15:0] slen;
  logic [NSLOT-1:0][15:0] bsum;
  logic [NSLOT-1:0]       fit;
  logic [31:0]            svc_w;
  logic [31:0]            pb_w;
  logic                   svc_act;
  logic                   sd_act;
  logic                   bd_act;
  logic [2:0]             sd_idx;
  logic [2:0]             bd_idx;
  logic [1:0]             cls;
  logic [14:0]            aggr_m;
  logic [14:0]            dmask;
  logic                   poe_vld;
  logic [7:0]             poe_addr;
  logic [3:0]             mcnt;
  logic                   slb_tk;
  logic                   fine_tk;
  logic                   coarse_tk;
  logic                   ok;
  logic                   grn;
  logic                   ylw;
  logic                   bylw;    // Bundle excess colour, kept out of service counters

  // Register decode: bit 9 marks a hit, low bits give the config word
  function automatic logic [9:0] dec(input logic [11:0] a);
    logic [9:0] w;
    w = 10'(a[11:2] - A_CFG_BASE[11:2]);
    if (a >= A_CFG_BASE && w < 10'(NCFG)) return {1'b1, w[8:0]};
    return 10'h000;
  endfunction : dec

  // Word that holds scale and gap for a bucket
  function automatic logic [7:0] scale_of(input logic [7:0] i);
    if ((i >= 8'(LB_SDE) && i < 8'(LB_BDC)) || i >= 8'(LB_BDE)) return 8'(i - 8'h08);
    return i;
  endfunction : scale_of

  // Read value of a mapped register
  function automatic logic [32:0] rd(input amp_st_t s, input logic [11:0] a);
    logic [9:0] d;
    d = dec(a);
    if (d[9]) return {1'b1, s.cfg[d[8:0]]};
    unique case (a)
      A_CTRL:   return {1'b1, 29'h0000_0000, s.ctrl};
      A_STATUS: return {1'b1, 17'h0_0000, s.fc};
      A_GREEN:  return {1'b1, s.green_cnt};
      A_YELLOW: return {1'b1, s.yellow_cnt};
      A_DROP:   return {1'b1, s.drop_cnt};
      default:  return 33'h0_0000_0000;
    endcase
  endfunction : rd

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) if (st[b]) m[8*b +: 8] = d[8*b +: 8];
    return m;
  endfunction : merge

  // Leak ticks for single, fine and coarse scales
  assign slb_tk    = (s_r.slb_cnt == 16'(SLB_TICK - 1));
  assign fine_tk   = (s_r.fine_cnt == 16'(FINE_TICK - 1));
  assign coarse_tk = (s_r.coarse_cnt == 7'(COARSE_TICK_CYC - 1));

  // Policer selection, mask stage and exit port for the frame in flight
  always_comb begin
    logic [6:0]  gap;
    logic [16:0] t17;
    gap = 7'h00;
    t17 = 17'h0_0000;
    svc_w = s_r.cfg[FB_SVC + int'(req.service_index)];
    pb_w  = s_r.cfg[FB_PORTB + int'(req.src_port)];
    svc_act = (svc_w[F_PIPE +: 2] == PIPE_NONE) || (req.pipe_pos >= svc_w[F_PIPE +: 2]);
    sd_idx = svc_w[F_SDIDX +: 3];
    sd_act = 1'b1;
    if (req.service_index == 3'h0 && sd_idx == 3'h0) begin
      sd_act = s_r.ctrl[C_QPOL_DEF];
      sd_idx = pb_w[F_QIDX +: 3];
    end
    bd_idx = svc_w[F_BDIDX +: 3];
    bd_act = 1'b1;
    if (req.service_index == 3'h0) begin
      bd_act = s_r.ctrl[C_PBUN_DEF];
      bd_idx = pb_w[F_BIDX +: 3];
    end
    cls = (req.traffic_class > 2'h2) ? 2'h2 : req.traffic_class;
    sidx[0] = 8'(LB_ACL + int'(req.acl_idx));
    sidx[1] = 8'(LB_PORT + int'(req.src_port));
    sidx[2] = 8'(LB_STORM + int'(req.storm_idx));
    sidx[3] = 8'(LB_BUM + 3 * int'(svc_w[F_BUMSET +: 2]) + int'(cls));
    sidx[4] = 8'(LB_SDC + int'(sd_idx));
    sidx[5] = 8'(LB_SDE + int'(sd_idx));
    sidx[6] = 8'(LB_BDC + int'(bd_idx));
    sidx[7] = 8'(LB_BDE + int'(bd_idx));
    for (int g = 0; g < NSLOT; g++) begin
      gap = s_r.cfg[scale_of(sidx[g])][F_GAP +: 7];
      t17 = {3'b000, req.frame_len} + {{10{gap[6]}}, gap};
      slen[g] = t17[16] ? 16'h0000 : t17[15:0];
    end
    aggr_m = s_r.cfg[FB_AGGR + int'(req.lag_hash_code)][14:0];
    dmask = req.fwd_mask & aggr_m;
    if (!req.routed && req.mask_mode != MODE_REDIRECT_VIA_GROUP_ENTRY) begin
      dmask = dmask & s_r.cfg[FB_SRC + int'(req.src_port)][14:0];
      dmask[req.src_port] = 1'b0;
      if (req.src_global_link_aggregate_vld)
        dmask = dmask & s_r.cfg[FB_SRC + GLOBAL_LINK_AGGREGATE_SRC_BASE + int'(req.src_global_link_aggregate)][14:0];
    end
    mcnt = s_r.cfg[FB_MBR + int'(req.dst_global_link_aggregate)][3:0];
    if (mcnt == 4'h0) mcnt = 4'h1;
    if (mcnt > 4'h8) mcnt = 4'h8;
    poe_vld  = s_r.ctrl[C_GLOBAL_LINK_AGGREGATE_EXIT] && req.dst_global_link_aggregate_vld;
    poe_addr = 8'(POE_BASE) + {2'b00, req.dst_global_link_aggregate, 3'b000} + {4'h0, req.lag_hash_code % mcnt};
  end

  // One conformance checker per policer slot
  for (genvar g = 0; g < NSLOT; g++) begin : g_bk
    amp_bucket u_bk (
      .lvl (s_r.lvl[sidx[g]]),
      .thr (s_r.cfg[sidx[g]][F_THR +: 12]),
      .len (slen[g]),
      .fit (fit[g]),
      .sum (bsum[g])
    );
  end

  // Next state: bus slave, bucket leak, flow control and frame policing
  always_comb begin
    logic [9:0]  d;
    logic [32:0] rv;
    logic        tk;
    logic [15:0] rate;
    logic [16:0] thr;
    logic [16:0] hys;
    d = 10'h000;
    rv = 33'h0_0000_0000;
    tk = 1'b0;
    rate = 16'h0000;
    thr = 17'h0_0000;
    hys = 17'h0_0000;
    s_nxt = s_r;
    ok = 1'b1;
    grn = 1'b0;
    ylw = 1'b0;
    bylw = 1'b0;
    s_nxt.slb_cnt    = slb_tk ? 16'h0000 : 16'(s_r.slb_cnt + 16'h0001);
    s_nxt.fine_cnt   = fine_tk ? 16'h0000 : 16'(s_r.fine_cnt + 16'h0001);
    s_nxt.coarse_cnt = coarse_tk ? 7'h00 : 7'(s_r.coarse_cnt + 7'h01);
    // Leak: single buckets on the fixed step, others on the chosen scale
    for (int i = 0; i < NLVL; i++) begin
      tk = (i < LB_BUM) ? slb_tk
         : (s_r.cfg[scale_of(8'(i))][F_SCALE] ? coarse_tk : fine_tk);
      rate = {4'h0, s_r.cfg[i][F_RATE +: 12]};
      if (tk) s_nxt.lvl[i] = (s_r.lvl[i] > rate) ? 16'(s_r.lvl[i] - rate) : 16'h0000;
    end
    // Port flow control with hysteresis
    for (int p = 0; p < NPORT; p++) begin
      thr = {1'b0, s_r.cfg[LB_PORT + p][F_THR +: 12], 4'h0};
      hys = {1'b0, s_r.cfg[FB_PORTB + p][F_HYST +: 12], 4'h0};
      if (thr == 17'h0_0000) s_nxt.fc[p] = 1'b0;  // A disabled port policer never pauses
      else if ({1'b0, s_r.lvl[LB_PORT + p]} > thr) s_nxt.fc[p] = 1'b1;
      else if ({1'b0, s_r.lvl[LB_PORT + p]} + hys < thr) s_nxt.fc[p] = 1'b0;
    end
    // Bus: responses retire on their handshake
    if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && rready) s_nxt.rvalid = 1'b0;
    if (awvalid && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    // Write once address and data are both held
    if (s_nxt.aw_held && s_nxt.w_held && !s_nxt.bvalid) begin
      d = dec(s_nxt.aw_addr);
      rv = rd(s_r, s_nxt.aw_addr);
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rv[32] ? 2'b00 : 2'b10;
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      if (d[9]) s_nxt.cfg[d[8:0]] = merge(s_r.cfg[d[8:0]], s_nxt.w_data, s_nxt.w_strb);
      else if (s_nxt.aw_addr == A_CTRL)
        s_nxt.ctrl = 3'(merge({29'h0000_0000, s_r.ctrl}, s_nxt.w_data, s_nxt.w_strb));
    end
    if (arvalid && s_r.arready) begin
      rv = rd(s_r, araddr);
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rv[31:0];
      s_nxt.rresp = rv[32] ? 2'b00 : 2'b10;
    end
    s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
    // Policer hierarchy; a failing bucket stops the charges behind it
    s_nxt.res_valid = req_valid;
    if (req_valid) begin
      if (req.acl_vld && !req.inner_acl_select) begin
        if (fit[0]) s_nxt.lvl[sidx[0]] = bsum[0];
        else ok = 1'b0;
      end
      for (int g = 1; g < 4; g++) begin
        if (ok && (g == 1 || (g == 2 && req.storm_vld) || (g == 3 && svc_act))) begin
          if (fit[g]) s_nxt.lvl[sidx[g]] = bsum[g];
          else ok = 1'b0;
        end
      end
      if (ok && sd_act && svc_act) begin
        if (fit[4]) begin
          s_nxt.lvl[sidx[4]] = bsum[4];
          grn = 1'b1;
        end else if (fit[5]) begin
          s_nxt.lvl[sidx[5]] = bsum[5];
          ylw = 1'b1;
        end else ok = 1'b0;
      end
      if (grn) s_nxt.green_cnt = 32'(s_r.green_cnt + 32'h0000_0001);
      if (ylw) s_nxt.yellow_cnt = 32'(s_r.yellow_cnt + 32'h0000_0001);
      if (ok && req.acl_vld && req.inner_acl_select) begin
        if (fit[0]) s_nxt.lvl[sidx[0]] = bsum[0];
        else ok = 1'b0;
      end
      if (ok && bd_act && svc_act) begin
        if (fit[6]) s_nxt.lvl[sidx[6]] = bsum[6];
        else if (fit[7]) begin
          s_nxt.lvl[sidx[7]] = bsum[7];
          bylw = 1'b1;
        end else ok = 1'b0;
      end
      if (!ok) s_nxt.drop_cnt = 32'(s_r.drop_cnt + 32'h0000_0001);
      s_nxt.res.drop     = !ok;
      s_nxt.res.yellow   = (ylw || bylw) && ok;
      s_nxt.res.dst_mask = ok ? dmask : 15'h0000;
      s_nxt.res.poe_vld  = poe_vld;
      s_nxt.res.poe_addr = poe_addr;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) s_r <= ST_RST;
    else s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign awready   = s_r.awready;
  assign wready    = s_r.wready;
  assign bvalid    = s_r.bvalid;
  assign bresp     = s_r.bresp;
  assign arready   = s_r.arready;
  assign rvalid    = s_r.rvalid;
  assign rdata     = s_r.rdata;
  assign rresp     = s_r.rresp;
  assign res_valid = s_r.res_valid;
  assign res       = s_r.res;
  assign fc_pause  = s_r.fc;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_no_hairpin;
    req_valid && !req.routed && req.mask_mode != MODE_REDIRECT_VIA_GROUP_ENTRY
      |=> res.dst_mask[$past(req.src_port)] == 1'b0;
  endproperty
  a_no_hairpin: assert property (p_no_hairpin) else $error("frame sent back to source port");

  property p_global_link_aggregate_src;
    req_valid && req.src_global_link_aggregate_vld && !req.routed && req.mask_mode != MODE_REDIRECT_VIA_GROUP_ENTRY
      |=> (res.dst_mask & ~$past(s_r.cfg[FB_SRC + GLOBAL_LINK_AGGREGATE_SRC_BASE + int'(req.src_global_link_aggregate)][14:0]))
          == 15'h0000;
  endproperty
  a_global_link_aggregate_src: assert property (p_global_link_aggregate_src) else $error("global group source mask not applied");

  property p_redirect;
    req_valid && !req.routed && req.mask_mode == MODE_REDIRECT_VIA_GROUP_ENTRY
      ##1 !res.drop |-> res.dst_mask == $past(req.fwd_mask & aggr_m);
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirect did not bypass source mask");

  property p_routed;
    req_valid && req.routed ##1 !res.drop |-> res.dst_mask == $past(req.fwd_mask & aggr_m);
  endproperty
  a_routed: assert property (p_routed) else $error("routed frame was source filtered");

  property p_aggr;
    req_valid |=> (res.dst_mask & ~$past(aggr_m)) == 15'h0000;
  endproperty
  a_aggr: assert property (p_aggr) else $error("aggregation mask not applied");

  property p_poe;
    req_valid && req.dst_global_link_aggregate_vld && s_r.ctrl[C_GLOBAL_LINK_AGGREGATE_EXIT]
      |=> res.poe_vld && res.poe_addr >= 8'(POE_BASE) && res.poe_addr <= 8'(POE_LAST)
          && (8'(res.poe_addr - 8'(POE_BASE)) >> 3) == {5'h00, $past(req.dst_global_link_aggregate)};
  endproperty
  a_poe: assert property (p_poe) else $error("exit port address wrong");

  property p_yellow;
    req_valid && ylw |=> s_r.yellow_cnt == $past(s_r.yellow_cnt) + 32'h0000_0001;
  endproperty
  a_yellow: assert property (p_yellow) else $error("yellow counter missed a frame");

  property p_slb_tick;
    slb_tk |=> s_r.slb_cnt == 16'h0000 ##1 s_r.slb_cnt == 16'h0001;
  endproperty
  a_slb_tick: assert property (p_slb_tick) else $error("leak tick counter wrong");

  property p_latency;
    req_valid |=> res_valid && (res.drop || res.dst_mask == ($past(dmask)));
  endproperty
  a_latency: assert property (p_latency) else $error("result not one cycle after request");
endmodule : amp_stage
`default_nettype wire

// file: src/amp_pkg.sv
// Constants and carrier types of the analyzer mask and policer stage
package amp_pkg;
  // Table sizes
  localparam int NPORT  = 15;
  localparam int NSRC   = 23;
  localparam int NAGGR  = 16;
  localparam int NGLAG  = 8;
  localparam int NSLOT  = 8;
  // Policer buckets; each bucket shares its index with its config word
  localparam int LB_ACL   = 0;
  localparam int LB_STORM = 32;
  localparam int LB_PORT  = 40;
  localparam int LB_BUM   = 55;
  localparam int LB_SDC   = 67;
  localparam int LB_SDE   = 75;
  localparam int LB_BDC   = 83;
  localparam int LB_BDE   = 91;
  localparam int NLVL     = 99;
  // Further config words behind the policer words
  localparam int FB_PORTB = 99;
  localparam int FB_SRC   = 114;
  localparam int FB_AGGR  = 137;
  localparam int FB_MBR   = 153;
  localparam int FB_SVC   = 161;
  localparam int NCFG     = 169;
  localparam int GLOBAL_LINK_AGGREGATE_SRC_BASE = 15;
  // Byte addresses on the register bus
  localparam logic [11:0] A_CTRL     = 12'h000;
  localparam logic [11:0] A_STATUS   = 12'h004;
  localparam logic [11:0] A_GREEN    = 12'h008;
  localparam logic [11:0] A_YELLOW   = 12'h00C;
  localparam logic [11:0] A_DROP     = 12'h010;
  localparam logic [11:0] A_CFG_BASE = 12'h400;
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  // Control bits
  localparam int C_GLOBAL_LINK_AGGREGATE_EXIT = 0;
  localparam int C_QPOL_DEF  = 1;
  localparam int C_PBUN_DEF  = 2;
  // Policer word fields; thresholds count 16-byte units
  localparam int F_RATE  = 0;
  localparam int F_THR   = 12;
  localparam int F_GAP   = 24;
  localparam int F_SCALE = 31;
  localparam int F_HYST  = 0;
  localparam int F_QIDX  = 12;
  localparam int F_BIDX  = 16;
  localparam int F_SDIDX = 0;
  localparam int F_BDIDX = 4;
  localparam int F_PIPE  = 8;
  localparam int F_BUMSET = 12;
  localparam logic [1:0] PIPE_NONE = 2'h0;
  localparam logic [2:0] MODE_REDIRECT_VIA_GROUP_ENTRY = 3'h4;
  // Exit port window of the port group table
  localparam int POE_BASE = 75;
  localparam int POE_LAST = 138;
  // Rate steps and leak tick periods
  localparam int CLK_HZ          = 100_000_000;
  localparam int SLB_STEP_BPS    = 25_040;
  localparam int FINE_STEP_BPS   = 16_000;
  localparam int COARSE_STEP_BPS = 8_000_000;
  localparam int SLB_TICK_CYC    = CLK_HZ * 8 / SLB_STEP_BPS;
  localparam int FINE_TICK_CYC   = CLK_HZ * 8 / FINE_STEP_BPS;
  localparam int COARSE_TICK_CYC = CLK_HZ * 8 / COARSE_STEP_BPS;

  typedef struct packed {
    logic [3:0]  src_port;
    logic [14:0] fwd_mask;
    logic [2:0]  mask_mode;
    logic        routed;
    logic [3:0]  lag_hash_code;
    logic        src_global_link_aggregate_vld;
    logic [2:0]  src_global_link_aggregate;
    logic        dst_global_link_aggregate_vld;
    logic [2:0]  dst_global_link_aggregate;
    logic [13:0] frame_len;
    logic [2:0]  service_index;
    logic        acl_vld;
    logic [4:0]  acl_idx;
    logic        inner_acl_select;
    logic        storm_vld;
    logic [2:0]  storm_idx;
    logic [1:0]  traffic_class;
    logic [1:0]  pipe_pos;
  } amp_req_t;

  typedef struct packed {
    logic [14:0] dst_mask;
    logic        drop;
    logic        yellow;
    logic        poe_vld;
    logic [7:0]  poe_addr;
  } amp_res_t;
endpackage : amp_pkg

// file: src/amp_bucket.sv
// Leaky bucket conformance check for one frame
`timescale 1ns/1ps
`default_nettype none
module amp_bucket (
  input  wire logic [15:0] lvl,  // Current fill
  input  wire logic [11:0] thr,  // Threshold, 16-byte units
  input  wire logic [15:0] len,  // Frame length after correction
  output logic             fit,  // Frame conforms
  output logic [15:0]      sum   // Fill after charging
);
  logic [16:0] tot;

  // A zero threshold disables the bucket
  always_comb begin
    tot = {1'b0, lvl} + {1'b0, len};
    fit = (thr == 12'h000) || (tot <= {1'b0, thr, 4'h0});
    sum = tot[16] ? 16'hFFFF : tot[15:0];
  end
endmodule : amp_bucket
`default_nettype wire

// file: bench/amp_partner.sv
// Upstream decision source and downstream result sink facing the stage
`timescale 1ns/1ps
`default_nettype none
module amp_partner import amp_pkg::*; (
  input  wire logic     aclk,       // Clock
  output logic          req_valid,  // Decision strobe
  output var amp_req_t  req,        // Decision fields
  input  wire logic     res_valid,  // Result strobe
  input  wire amp_res_t res         // Result fields
);
  // Idle source at time zero
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // One decision per call; the result is caught in the cycle it stands
  task automatic send(input amp_req_t f, output logic v, output amp_res_t r);
    @(posedge aclk);
    req_valid <= 1'b1;
    req       <= f;
    @(posedge aclk);
    req_valid <= 1'b0;
    req       <= ~f;  // Unqualified fields never show the last decision
    @(posedge aclk);
    v = res_valid;
    r = res;
  endtask : send
endmodule : amp_partner
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench of the mask and policer stage
`timescale 1ns/1ps
`default_nettype none
module testbench import amp_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, req_valid, res_valid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [14:0] fc_pause;
  amp_req_t    req;
  amp_res_t    res;
  int          failures, compares, cycles;
  amp_stage #(.SLB_TICK(8), .FINE_TICK(10)) u_amp_stage (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .req_valid(req_valid), .req(req),
    .res_valid(res_valid), .res(res), .fc_pause(fc_pause));
  amp_partner u_amp_partner (.aclk(aclk), .req_valid(req_valid), .req(req),
    .res_valid(res_valid), .res(res));
  // Clock and bus idle values
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
  end
  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Write with both channels offered together, response awaited
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic cfg(input int k, input logic [31:0] d);
    logic [1:0] rsp;
    wr(A_CFG_BASE + 12'(k * 4), d, rsp);
  endtask : cfg
  // Send one frame and compare its destination set
  task automatic frame(input amp_req_t f, input logic [14:0] exp, output amp_res_t r);
    logic v;
    u_amp_partner.send(f, v, r);
    chk("res_valid", 32'h0000_0001, {31'h0, v});
    chk("dst_mask", {17'h0, exp}, {17'h0, r.dst_mask});
  endtask : frame
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  rsp;
    wr(12'h020, 32'h0000_0001, rsp);
    chk("unmapped bresp", 32'h0000_0002, {30'h0, rsp});
    rd(12'h020, d, rsp);
    chk("unmapped rresp", 32'h0000_0002, {30'h0, rsp});
    chk("unmapped rdata", 32'h0000_0000, d);
  endtask : t_regs
  task automatic t_masks();
    amp_req_t   f;
    amp_res_t   r;
    f = '0;
    f.src_port = 4'h1;
    f.fwd_mask = 15'h7FFF;
    cfg(FB_AGGR, 32'h0000_7FFF);
    cfg(FB_AGGR + 3, 32'h0000_7FEF);  // Hash 3 keeps port 3 of the pair 3 and 4
    cfg(FB_SRC + 1, 32'h0000_7FFB);  // LAG mate port 2 cleared
    frame(f, 15'h7FF9, r);
    f.routed = 1'b1;
    frame(f, 15'h7FFF, r);
    f.routed = 1'b0;
    f.mask_mode = MODE_REDIRECT_VIA_GROUP_ENTRY;
    frame(f, 15'h7FFF, r);
    f.mask_mode = 3'h0;
    cfg(FB_SRC + GLOBAL_LINK_AGGREGATE_SRC_BASE, 32'h0000_7F0F);  // Global members 4-7 cleared
    f.src_global_link_aggregate_vld = 1'b1;
    frame(f, 15'h7F09, r);
    f.src_global_link_aggregate_vld = 1'b0;
    f.lag_hash_code = 4'h3;
    frame(f, 15'h7FE9, r);
  endtask : t_masks
  task automatic t_exit();
    amp_req_t   f;
    amp_res_t   r;
    logic [1:0] rsp;
    f = '0;
    wr(A_CTRL, 32'h0000_0001, rsp);
    cfg(FB_MBR + 2, 32'h0000_0003);  // Three members in group 2
    f.dst_global_link_aggregate_vld = 1'b1;
    f.dst_global_link_aggregate = 3'h2;
    f.lag_hash_code = 4'h7;
    frame(f, 15'h0000, r);
    chk("poe_vld", 32'h0000_0001, {31'h0, r.poe_vld});
    chk("poe_addr", 32'd92, {24'h0, r.poe_addr});
  endtask : t_exit
  task automatic t_acl();
    amp_req_t   f;
    amp_res_t   r;
    logic [31:0] d;
    logic [1:0]  rsp;
    f = '0;
    f.src_port = 4'h1;
    f.fwd_mask = 15'h7FFF;
    f.acl_vld = 1'b1;
    f.acl_idx = 5'd5;
    f.frame_len = 14'd16;
    cfg(LB_ACL + 5, 32'h0000_1000);  // One 16-byte unit, no leak
    frame(f, 15'h7FF9, r);
    frame(f, 15'h0000, r);
    chk("drop", 32'h0000_0001, {31'h0, r.drop});
    rd(A_DROP, d, rsp);
    chk("drop count", 32'h0000_0001, d);
  endtask : t_acl
  // Service policer as queue policer: green, then yellow, then port pause
  task automatic t_svc();
    amp_req_t    f;
    amp_res_t    r;
    logic [31:0] d;
    logic [1:0]  rsp;
    f = '0;
    f.src_port = 4'h1;
    f.fwd_mask = 15'h7FFF;
    f.frame_len = 14'd16;
    wr(A_CTRL, 32'h0000_0003, rsp);  // Queue policer on, index 0
    cfg(LB_SDC, 32'h0000_1000);
    cfg(LB_SDE, 32'h0000_1000);
    frame(f, 15'h7FF9, r);
    chk("green frame yellow", 32'h0000_0000, {31'h0, r.yellow});
    frame(f, 15'h7FF9, r);
    chk("excess frame yellow", 32'h0000_0001, {31'h0, r.yellow});
    rd(A_GREEN, d, rsp);
    chk("green count", 32'h0000_0001, d);
    rd(A_YELLOW, d, rsp);
    chk("yellow count", 32'h0000_0001, d);
    chk("pause off", 32'h0000_0000, {17'h0, fc_pause});
    cfg(LB_PORT + 1, 32'h0000_1000);  // Port 1 holds 48 bytes over a 16-byte threshold
    rd(A_STATUS, d, rsp);
    chk("status", 32'h0000_0002, d);
    chk("pause on", 32'h0000_0002, {17'h0, fc_pause});
  endtask : t_svc
  // Main sequence
  initial begin
    failures = 0;
    compares = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_masks();
    t_exit();
    t_acl();
    t_svc();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
